// file: bench/ifsb_properties.sv
// Concurrent checks of the interrupt flag bank, seen from its top-level ports.
`timescale 1ns/1ns
`default_nettype none
`include "ifsb_params.svh"
module ifsb_properties
  import ifsb_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and one source line.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ext_irq_zero_flag_set_i,
  // Outputs toward the CPU.
  input wire logic [63:0] cpu_req_o,
  input wire logic irq_o
);
  // Implemented bits, a flag-word address and a taken write to word 0 or its enable.
  wire logic [63:0] impl_w = {`IFSB_MASK3, `IFSB_MASK2, `IFSB_MASK1, `IFSB_MASK0};
  wire logic is_flag_w = (wb_adr_i[7:4] == 4'h0) && (wb_adr_i[1:0] == 2'h0);
  wire logic [15:0] rd_mask_w = impl_w[{wb_adr_i[3:2], 4'h0} +: 16];
  wire logic wr0_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
    (wb_adr_i == `IFSB_OFF_FLAGS0 || wb_adr_i == `IFSB_OFF_EN0);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A request is taken when the slave is idle; the answer is a single pulse.
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  ack_answer_a: assert property (s_take |=> s_answer)
    else $error("bus request not answered by one ack pulse");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data changed outside a read answer");
  rd_unimpl_a: assert property (wb_ack_o && !wb_we_i && is_flag_w |->
    (wb_dat_o[15:0] & ~rd_mask_w) == 16'h0 && wb_dat_o[31:16] == 16'h0)
    else $error("unassigned flag bit read as one");
  req_unimpl_a: assert property ((cpu_req_o & ~impl_w) == 64'h0)
    else $error("request on unassigned bit");
  // The registered request lags the source or bus write by two edges.
  req_cause_a: assert property ($rose(cpu_req_o[0]) |->
    $past(ext_irq_zero_flag_set_i, 2) || $past(wr0_w, 2))
    else $error("request rose without source or write");
  req_hold_a: assert property ($fell(cpu_req_o[0]) |-> $past(wr0_w, 2) || $past(rst_i))
    else $error("request fell without software write");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
    cpu_req_o == 64'h0 && !irq_o && !wb_ack_o)
    else $error("outputs not cleared by reset");
endmodule
bind ifsb_top ifsb_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .ext_irq_zero_flag_set_i, .cpu_req_o, .irq_o);
`default_nettype wire

// file: bench/ifsb_src_model.sv
// Behavioural model of the peripheral sources that raise flag requests.
`timescale 1ns/1ns
`default_nettype none
module ifsb_src_model (
  // Clock.
  input wire logic clk_i,
  // Requests in flag-word layout and pacing choice.
  input wire logic [63:0] fire_i,
  input wire logic slow_i,
  // Request lines toward the flag bank.
  output logic [63:0] set_o
);
  logic [63:0] late_r;
  // A slow source answers one cycle after it is asked.
  always_ff @(posedge clk_i) begin
    late_r <= fire_i;
  end
  // Each request is a one-cycle high level; lines idle low.
  assign set_o = slow_i ? late_r : fire_i;
endmodule
`default_nettype wire

// file: bench/interrupt_flag_status_bank_tb.sv
// Self-checking bench for the interrupt flag bank.
`timescale 1ns/1ns
`default_nettype none
`include "ifsb_params.svh"
module interrupt_flag_status_bank_tb
  import ifsb_pkg::*;
;
  localparam logic [63:0] IMP = {`IFSB_MASK3, `IFSB_MASK2, `IFSB_MASK1, `IFSB_MASK0};
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq, slow;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, rdo;
  logic [63:0] fire, set_w, cpu_req, wb_rdat;
  ifsb_word_t exp_f [4];
  ifsb_word_t exp_e [4];
  int err_count, num_checks;

  // Free-running clock of 4 ns.
  always #2 clk_i = ~clk_i;

  ifsb_src_model u_src (.clk_i(clk_i), .fire_i(fire), .slow_i(slow), .set_o(set_w));
  ifsb_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(rdo), .wb_ack_o(wb_ack), .cpu_req_o(cpu_req), .irq_o(irq),
    .mem_prog_flag_set_i(set_w[15]), .conv_done_flag_set_i(set_w[13]),
    .serial_a_tx_flag_set_i(set_w[12]), .serial_a_rx_flag_set_i(set_w[11]),
    .cc_timer_b_flag_set_i(set_w[8]), .cc_timer_a_flag_set_i(set_w[7]),
    .cc_event_d_flag_set_i(set_w[6]), .cc_event_c_flag_set_i(set_w[5]),
    .timer_one_flag_set_i(set_w[3]), .cc_event_b_flag_set_i(set_w[2]),
    .cc_event_a_flag_set_i(set_w[1]), .ext_irq_zero_flag_set_i(set_w[0]),
    .serial_b_tx_flag_set_i(set_w[31]), .serial_b_rx_flag_set_i(set_w[30]),
    .ext_irq_two_flag_set_i(set_w[29]), .cc_timer_d_flag_set_i(set_w[28]),
    .cc_timer_c_flag_set_i(set_w[27]), .cc_event_e_flag_set_i(set_w[22]),
    .ext_irq_one_flag_set_i(set_w[20]), .pin_change_flag_set_i(set_w[19]),
    .comparator_flag_set_i(set_w[18]), .sync_a_collision_flag_set_i(set_w[17]),
    .sync_a_event_flag_set_i(set_w[16]), .cc_timer_e_flag_set_i(set_w[41]),
    .calendar_flag_set_i(set_w[62]), .sync_b_collision_flag_set_i(set_w[50]),
    .sync_b_event_flag_set_i(set_w[49]));

  // Expected word after a byte-lane write; unassigned bits never take a value.
  function automatic ifsb_word_t mrg(input ifsb_word_t o, d, input logic [1:0] s, input int i);
    ifsb_word_t l;
    l = {{8{s[1]}}, {8{s[0]}}} & IMP[i*16 +: 16];
    return (o & ~l) | (d & l);
  endfunction

  // Expected requests toward the CPU: flags gated by enables.
  function automatic logic [63:0] rq();
    for (int i = 0; i < 4; i++) rq[i*16 +: 16] = exp_f[i] & exp_e[i];
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input ifsb_word_t d, input logic [1:0] s);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= {16'h0, d};
    wb_sel <= {2'b00, s};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    wb_rdat = 64'(rdo);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // One-cycle request from the source model.
  task automatic pulse(input logic [63:0] f);
    @(posedge clk_i);
    fire <= f;
    @(posedge clk_i);
    fire <= 64'h0;
  endtask

  initial begin
    int r;
    ifsb_word_t d;
    logic [1:0] s;
    logic [63:0] f;
    {clk_i, wb_cyc, wb_stb, wb_we, slow, wb_adr, wb_sel, wb_dat, fire} = '0;
    rst_i = 1'b1;
    exp_f = '{default: 16'h0};
    exp_e = '{default: 16'h0};
    void'($urandom(32'h73e75563));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Every register reads zero after reset, and so does an unmapped place.
    for (int a = 0; a < 12; a++) begin
      wb(1'b0, 8'(a * 4), 16'h0, 2'b11);
      chk(wb_rdat, 64'h0);
    end
    // All ones then all zeros: only assigned bits hold a value.
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'(i * 4), 16'hffff, 2'b11);
      wb(1'b0, 8'(i * 4), 16'h0, 2'b11);
      chk(wb_rdat, {48'h0, IMP[i*16 +: 16]});
      wb(1'b1, 8'(i * 4), 16'h0, 2'b11);
    end
    wb(1'b1, 8'h30, 16'hffff, 2'b11);
    wb(1'b0, 8'h30, 16'h0, 2'b11);
    chk(wb_rdat, 64'h0);
    // Random source requests, paced promptly or slowly, mixed with random writes.
    for (int k = 0; k < 40; k++) begin
      f = {$urandom, $urandom} & IMP;
      @(posedge clk_i);
      slow <= 1'($urandom);
      pulse(f);
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 4; i++) exp_f[i] |= f[i*16 +: 16];
      r = $urandom % 8;
      d = 16'($urandom);
      s = 2'($urandom);
      wb(1'b1, 8'(r * 4), d, s);
      if (r < 4) exp_f[r] = mrg(exp_f[r], d, s, r);
      else exp_e[r-4] = mrg(exp_e[r-4], d, s, r - 4);
      repeat (2) @(posedge clk_i);
      chk(cpu_req, rq());
      for (int i = 0; i < 4; i++) begin
        wb(1'b0, 8'(i * 4), 16'h0, 2'b11);
        chk(wb_rdat, {48'h0, exp_f[i]});
        wb(1'b0, 8'(i * 4 + 16), 16'h0, 2'b11);
        chk(wb_rdat, {48'h0, exp_e[i]});
      end
    end
    // A source request in the cycle a clearing write is taken must survive.
    @(posedge clk_i);
    slow <= 1'b0;
    fork
      wb(1'b1, `IFSB_OFF_FLAGS0, 16'h0, 2'b11);
      pulse(64'h1);
    join
    wb(1'b0, `IFSB_OFF_FLAGS0, 16'h0, 2'b11);
    chk(wb_rdat, 64'h1);
    // Summary interrupt: clear, enable, raise, mask, unmask and clear again.
    wb(1'b1, `IFSB_OFF_EVT_CLR, 16'hf, 2'b11);
    wb(1'b1, `IFSB_OFF_EVT_EN, 16'hf, 2'b11);
    repeat (2) @(posedge clk_i);
    chk(64'(irq), 64'h0);
    pulse(64'h1 << 62);
    repeat (4) @(posedge clk_i);
    chk(64'(irq), 64'h1);
    wb(1'b0, `IFSB_OFF_EVT_STAT, 16'h0, 2'b11);
    chk(wb_rdat, 64'h8);
    wb(1'b1, `IFSB_OFF_EVT_EN, 16'h0, 2'b11);
    repeat (2) @(posedge clk_i);
    chk(64'(irq), 64'h0);
    wb(1'b1, `IFSB_OFF_EVT_EN, 16'hf, 2'b11);
    repeat (2) @(posedge clk_i);
    chk(64'(irq), 64'h1);
    wb(1'b1, `IFSB_OFF_EVT_CLR, 16'h8, 2'b11);
    repeat (2) @(posedge clk_i);
    chk(64'(irq), 64'h0);
    // A reset in mid-run, with every flag and status bit set, must clear them all.
    pulse(IMP);
    repeat (4) @(posedge clk_i);
    chk(64'(irq), 64'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(cpu_req, 64'h0);
    chk(64'(irq), 64'h0);
    for (int a = 0; a < 11; a++) begin
      wb(1'b0, 8'(a * 4), 16'h0, 2'b11);
      chk(wb_rdat, 64'h0);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: verilog/ifsb_flag_reg.sv
// One 16-bit interrupt flag register with hardware set and software write.
`timescale 1ns/1ns
`default_nettype none
`include "ifsb_params.svh"
module ifsb_flag_reg
  import ifsb_pkg::*;
#(
  parameter ifsb_word_t IMPL_MASK = 16'hffff
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Hardware requests, one bit per source.
  input wire logic [15:0] hw_set_i,
  // Software write port.
  input wire logic wr_i,
  input wire logic [1:0] wr_sel_i,
  input wire logic [15:0] wr_dat_i,
  // Flag state and set report.
  output logic [15:0] flags_o,
  output logic hit_o
);

  logic [15:0] flags_r;
  logic [15:0] flags_nxt;
  logic [15:0] wmask;
  logic [15:0] set_now;
  logic hit_r;

  // ----------------------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------------------
  // Unimplemented positions are masked out, so they never store a one.
  assign set_now = hw_set_i & IMPL_MASK; // RQ1 RQ4
  assign wmask = wr_i ? ifsb_lane_mask(wr_sel_i) : 16'h0000;
  // The set term is OR-ed last so a request in the clearing cycle is kept.
  assign flags_nxt = (((flags_r & ~wmask) | (wr_dat_i & wmask)) & IMPL_MASK)
    | set_now; // RQ2 RQ12

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  // Flags clear on reset so nothing is pending after power-up.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= `IFSB_FLAG_RST; // RQ3
      hit_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      hit_r <= |set_now;
    end
  end

  assign flags_o = flags_r;
  assign hit_o = hit_r;

endmodule
`default_nettype wire

// file: verilog/ifsb_params.svh
// Offsets, field positions, masks and reset values of the interrupt flag bank.
`ifndef IFSB_PARAMS_SVH
`define IFSB_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------------
`define IFSB_OFF_FLAGS0 8'h00
`define IFSB_OFF_FLAGS1 8'h04
`define IFSB_OFF_FLAGS2 8'h08
`define IFSB_OFF_FLAGS3 8'h0c
`define IFSB_OFF_EN0 8'h10
`define IFSB_OFF_EN1 8'h14
`define IFSB_OFF_EN2 8'h18
`define IFSB_OFF_EN3 8'h1c
`define IFSB_OFF_EVT_STAT 8'h20
`define IFSB_OFF_EVT_CLR 8'h24
`define IFSB_OFF_EVT_EN 8'h28

// ----------------------------------------------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------------------------------------------
`define IFSB_MASK0 16'hb9ef
`define IFSB_MASK1 16'hf85f
`define IFSB_MASK2 16'h0200
`define IFSB_MASK3 16'h4006
`define IFSB_FLAG_RST 16'h0000
`define IFSB_EN_RST 16'h0000
`define IFSB_EVT_RST 4'h0

// ----------------------------------------------------------------------------
// Flag positions, first flag register
// ----------------------------------------------------------------------------
`define IFSB_B_MEM_PROG 15
`define IFSB_B_CONV_DONE 13
`define IFSB_B_SER_A_TX 12
`define IFSB_B_SER_A_RX 11
`define IFSB_B_CC_TMR_B 8
`define IFSB_B_CC_TMR_A 7
`define IFSB_B_CC_EVT_D 6
`define IFSB_B_CC_EVT_C 5
`define IFSB_B_TIMER_ONE 3
`define IFSB_B_CC_EVT_B 2
`define IFSB_B_CC_EVT_A 1
`define IFSB_B_EXT_ZERO 0

// ----------------------------------------------------------------------------
// Flag positions, second to fourth flag registers
// ----------------------------------------------------------------------------
`define IFSB_B_SER_B_TX 15
`define IFSB_B_SER_B_RX 14
`define IFSB_B_EXT_TWO 13
`define IFSB_B_CC_TMR_D 12
`define IFSB_B_CC_TMR_C 11
`define IFSB_B_CC_EVT_E 6
`define IFSB_B_EXT_ONE 4
`define IFSB_B_PIN_CHG 3
`define IFSB_B_COMPARATOR 2
`define IFSB_B_SYNC_A_COLL 1
`define IFSB_B_SYNC_A_EVT 0
`define IFSB_B_CC_TMR_E 9
`define IFSB_B_CALENDAR 14
`define IFSB_B_SYNC_B_COLL 2
`define IFSB_B_SYNC_B_EVT 1

`endif

// file: verilog/ifsb_pkg.sv
// Types and helper functions shared by the interrupt flag bank.
`default_nettype none
package ifsb_pkg;

  // One 16-bit flag or enable word.
  typedef logic [15:0] ifsb_word_t;

  // Bus slave states: idle, then one cycle of acknowledge.
  typedef enum logic {
    IFSB_IDLE = 1'b0,
    IFSB_ACK = 1'b1
  } ifsb_bus_state_t;

  // Expands the two low byte selects into a 16-bit write mask.
  function automatic ifsb_word_t ifsb_lane_mask(input logic [1:0] sel);
    ifsb_lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

endpackage
`default_nettype wire

// file: verilog/ifsb_top.sv
// Interrupt flag status bank with enables, event status and Wishbone slave.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ifsb_params.svh"
//
// Summary of operation
// (RQ1) A source request sets its flag bit to one; zero means none recorded.
// (RQ2) Every implemented flag is readable and writable by software.
// (RQ3) All flags are zero after reset.
// (RQ4) Unassigned bit positions ignore writes and read zero.
// (RQ5) Register 0 high byte: mem prog 15, conv 13, serial A 12/11, timer B 8.
// (RQ6) Register 0 low byte: timer A 7, events D/C 6/5, timer 3, B/A 2/1, ext 0.
// (RQ7) Register 1: serial B 15/14, ext two 13, timers D 12, C 11.
// (RQ8) Register 1: event E 6, ext one 4, pin 3, comparator 2, sync A 1/0.
// (RQ9) Register 2 holds only the timer E flag at bit 9.
// (RQ10) Register 3: calendar 14, sync B collision 2, sync B event 1.
// (RQ11) A set flag requests the CPU only when its enable bit is one.
// (RQ12) Flags stay set until software writes zero; a coincident set wins.
//
module ifsb_top
  import ifsb_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Requests of the first flag register's sources.
  input wire logic mem_prog_flag_set_i,
  input wire logic conv_done_flag_set_i,
  input wire logic serial_a_tx_flag_set_i,
  input wire logic serial_a_rx_flag_set_i,
  input wire logic cc_timer_b_flag_set_i,
  input wire logic cc_timer_a_flag_set_i,
  input wire logic cc_event_d_flag_set_i,
  input wire logic cc_event_c_flag_set_i,
  input wire logic timer_one_flag_set_i,
  input wire logic cc_event_b_flag_set_i,
  input wire logic cc_event_a_flag_set_i,
  input wire logic ext_irq_zero_flag_set_i,
  // Requests of the second flag register's sources.
  input wire logic serial_b_tx_flag_set_i,
  input wire logic serial_b_rx_flag_set_i,
  input wire logic ext_irq_two_flag_set_i,
  input wire logic cc_timer_d_flag_set_i,
  input wire logic cc_timer_c_flag_set_i,
  input wire logic cc_event_e_flag_set_i,
  input wire logic ext_irq_one_flag_set_i,
  input wire logic pin_change_flag_set_i,
  input wire logic comparator_flag_set_i,
  input wire logic sync_a_collision_flag_set_i,
  input wire logic sync_a_event_flag_set_i,
  // Requests of the third and fourth flag registers' sources.
  input wire logic cc_timer_e_flag_set_i,
  input wire logic calendar_flag_set_i,
  input wire logic sync_b_collision_flag_set_i,
  input wire logic sync_b_event_flag_set_i,
  // Requests toward the CPU and the summary interrupt.
  output logic [63:0] cpu_req_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  localparam ifsb_word_t MASKS [4] = '{
    `IFSB_MASK0, `IFSB_MASK1, `IFSB_MASK2, `IFSB_MASK3
  };

  ifsb_bus_state_t state_r;
  ifsb_bus_state_t state_nxt;
  logic [31:0] rdat_r;
  logic [63:0] req_r;
  logic irq_r;
  logic [3:0] evt_r;
  logic [3:0] evt_nxt;
  logic [3:0] evt_en_r;
  logic [3:0] hit;
  ifsb_word_t set_vec [4];
  ifsb_word_t flags [4];
  ifsb_word_t en_r [4];
  logic [3:0] flag_wr;
  logic [3:0] en_wr;
  logic req_new;
  logic do_wr;
  logic aligned;
  logic [31:0] rd_mux;
  logic [3:0] evt_clr;
  logic [15:0] en_wmask;

  // ----------------------------------------------------------------------------
  // Source gathering
  // ----------------------------------------------------------------------------
  // First flag register; bit 4 and bits 10..9, 14 have no source.
  always_comb begin
    set_vec[0] = 16'h0000;
    set_vec[0][`IFSB_B_MEM_PROG] = mem_prog_flag_set_i; // RQ5
    set_vec[0][`IFSB_B_CONV_DONE] = conv_done_flag_set_i; // RQ5
    set_vec[0][`IFSB_B_SER_A_TX] = serial_a_tx_flag_set_i; // RQ5
    set_vec[0][`IFSB_B_SER_A_RX] = serial_a_rx_flag_set_i; // RQ5
    set_vec[0][`IFSB_B_CC_TMR_B] = cc_timer_b_flag_set_i; // RQ5
    set_vec[0][`IFSB_B_CC_TMR_A] = cc_timer_a_flag_set_i; // RQ6
    set_vec[0][`IFSB_B_CC_EVT_D] = cc_event_d_flag_set_i; // RQ6
    set_vec[0][`IFSB_B_CC_EVT_C] = cc_event_c_flag_set_i; // RQ6
    set_vec[0][`IFSB_B_TIMER_ONE] = timer_one_flag_set_i; // RQ6
    set_vec[0][`IFSB_B_CC_EVT_B] = cc_event_b_flag_set_i; // RQ6
    set_vec[0][`IFSB_B_CC_EVT_A] = cc_event_a_flag_set_i; // RQ6
    set_vec[0][`IFSB_B_EXT_ZERO] = ext_irq_zero_flag_set_i; // RQ6
  end

  // Second flag register; bits 10..7 and 5 have no source.
  always_comb begin
    set_vec[1] = 16'h0000;
    set_vec[1][`IFSB_B_SER_B_TX] = serial_b_tx_flag_set_i; // RQ7
    set_vec[1][`IFSB_B_SER_B_RX] = serial_b_rx_flag_set_i; // RQ7
    set_vec[1][`IFSB_B_EXT_TWO] = ext_irq_two_flag_set_i; // RQ7
    set_vec[1][`IFSB_B_CC_TMR_D] = cc_timer_d_flag_set_i; // RQ7
    set_vec[1][`IFSB_B_CC_TMR_C] = cc_timer_c_flag_set_i; // RQ7
    set_vec[1][`IFSB_B_CC_EVT_E] = cc_event_e_flag_set_i; // RQ8
    set_vec[1][`IFSB_B_EXT_ONE] = ext_irq_one_flag_set_i; // RQ8
    set_vec[1][`IFSB_B_PIN_CHG] = pin_change_flag_set_i; // RQ8
    set_vec[1][`IFSB_B_COMPARATOR] = comparator_flag_set_i; // RQ8
    set_vec[1][`IFSB_B_SYNC_A_COLL] = sync_a_collision_flag_set_i; // RQ8
    set_vec[1][`IFSB_B_SYNC_A_EVT] = sync_a_event_flag_set_i; // RQ8
  end

  // Third and fourth flag registers are sparse.
  always_comb begin
    set_vec[2] = 16'h0000;
    set_vec[2][`IFSB_B_CC_TMR_E] = cc_timer_e_flag_set_i; // RQ9
    set_vec[3] = 16'h0000;
    set_vec[3][`IFSB_B_CALENDAR] = calendar_flag_set_i; // RQ10
    set_vec[3][`IFSB_B_SYNC_B_COLL] = sync_b_collision_flag_set_i; // RQ10
    set_vec[3][`IFSB_B_SYNC_B_EVT] = sync_b_event_flag_set_i; // RQ10
  end

  // ----------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------
  // A request is served once: the write lands on the edge that raises ack.
  assign req_new = wb_cyc_i && wb_stb_i && (state_r == IFSB_IDLE);
  assign do_wr = req_new && wb_we_i;
  assign aligned = (wb_adr_i[1:0] == 2'b00);

  // One strobe per writable register; misaligned addresses write nothing.
  assign flag_wr[0] = do_wr && (wb_adr_i == `IFSB_OFF_FLAGS0); // RQ2
  assign flag_wr[1] = do_wr && (wb_adr_i == `IFSB_OFF_FLAGS1); // RQ2
  assign flag_wr[2] = do_wr && (wb_adr_i == `IFSB_OFF_FLAGS2); // RQ2
  assign flag_wr[3] = do_wr && (wb_adr_i == `IFSB_OFF_FLAGS3); // RQ2
  assign en_wr[0] = do_wr && (wb_adr_i == `IFSB_OFF_EN0);
  assign en_wr[1] = do_wr && (wb_adr_i == `IFSB_OFF_EN1);
  assign en_wr[2] = do_wr && (wb_adr_i == `IFSB_OFF_EN2);
  assign en_wr[3] = do_wr && (wb_adr_i == `IFSB_OFF_EN3);
  assign en_wmask = ifsb_lane_mask(wb_sel_i[1:0]);

  // The clear register is write-only; a one in a selected lane clears.
  assign evt_clr = (do_wr && (wb_adr_i == `IFSB_OFF_EVT_CLR) && wb_sel_i[0])
    ? wb_dat_i[3:0] : 4'h0;

  // Read selection; unmapped or misaligned addresses return zero.
  assign rd_mux =
    !aligned ? 32'h0000_0000 :
    (wb_adr_i == `IFSB_OFF_FLAGS0) ? {16'h0000, flags[0]} :
    (wb_adr_i == `IFSB_OFF_FLAGS1) ? {16'h0000, flags[1]} :
    (wb_adr_i == `IFSB_OFF_FLAGS2) ? {16'h0000, flags[2]} :
    (wb_adr_i == `IFSB_OFF_FLAGS3) ? {16'h0000, flags[3]} :
    (wb_adr_i == `IFSB_OFF_EN0) ? {16'h0000, en_r[0]} :
    (wb_adr_i == `IFSB_OFF_EN1) ? {16'h0000, en_r[1]} :
    (wb_adr_i == `IFSB_OFF_EN2) ? {16'h0000, en_r[2]} :
    (wb_adr_i == `IFSB_OFF_EN3) ? {16'h0000, en_r[3]} :
    (wb_adr_i == `IFSB_OFF_EVT_STAT) ? {28'h0000000, evt_r} :
    (wb_adr_i == `IFSB_OFF_EVT_EN) ? {28'h0000000, evt_en_r} :
    32'h0000_0000;

  // ----------------------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------------------
  // Ack lasts exactly one cycle, then the slave idles for one cycle at least.
  always_comb begin
    case (state_r)
      IFSB_IDLE: begin
        state_nxt = req_new ? IFSB_ACK : IFSB_IDLE;
      end
      IFSB_ACK: begin
        state_nxt = IFSB_IDLE;
      end
      default: begin
        state_nxt = IFSB_IDLE;
      end
    endcase
  end

  // Read data is captured together with a read ack and held until the next read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= IFSB_IDLE;
      rdat_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      if (req_new && !wb_we_i) begin
        rdat_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Flag registers and enables
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bank
      ifsb_flag_reg #(
        .IMPL_MASK(MASKS[gi])
      ) u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hw_set_i(set_vec[gi]),
        .wr_i(flag_wr[gi]),
        .wr_sel_i(wb_sel_i[1:0]),
        .wr_dat_i(wb_dat_i[15:0]),
        .flags_o(flags[gi]),
        .hit_o(hit[gi])
      );

      // Enables share the flag layout; unused positions stay zero.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          en_r[gi] <= `IFSB_EN_RST;
        end else if (en_wr[gi]) begin
          en_r[gi] <= ((en_r[gi] & ~en_wmask) | (wb_dat_i[15:0] & en_wmask))
            & MASKS[gi]; // RQ4
        end
      end

      // Gating adds one cycle of latency but keeps the output glitch free.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          req_r[gi*16 +: 16] <= 16'h0000;
        end else begin
          req_r[gi*16 +: 16] <= flags[gi] & en_r[gi]; // RQ11
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Event status and summary interrupt
  // ----------------------------------------------------------------------------
  // A new set of any flag in register n marks status bit n; the set wins.
  assign evt_nxt = (evt_r & ~evt_clr) | hit; // RQ12

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_r <= `IFSB_EVT_RST;
      evt_en_r <= `IFSB_EVT_RST;
      irq_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      if (do_wr && (wb_adr_i == `IFSB_OFF_EVT_EN) && wb_sel_i[0]) begin
        evt_en_r <= wb_dat_i[3:0];
      end
      irq_r <= |(evt_r & evt_en_r);
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign wb_ack_o = (state_r == IFSB_ACK);
  assign wb_dat_o = rdat_r;
  assign cpu_req_o = req_r;
  assign irq_o = irq_r;

endmodule
`default_nettype wire
